// File: common/hhid_pkg.sv
// Constants and types for the high-speed interface/endpoint descriptor source
// Behaviour
// - The shared-translator interface descriptor is nine bytes of type 04h, with interface, alternate setting and subclass zero, one endpoint and class 09h.
// - The shared-translator interface protocol byte is 00h with one interface reported and 01h with two interfaces reported.
// - The shared-translator status-change endpoint descriptor is seven bytes of type 05h, address 81h, attributes 03h, packet size 0001h and interval 0Ch.
// - The per-port interface descriptor matches the shared one except alternate setting 01h and protocol 02h.
// - The per-port interface descriptor is offered only when per-port translator support is advertised.
// - The per-port endpoint descriptor is returned only when per-port support is advertised and holds 81h, 03h, 0001h and 0Ch.
// - Every interface descriptor variant reports string index 00h at offset 8.
// - The other-speed total length is 0019h with the per-port option off and 0029h with it on.
package hhid_pkg;

  typedef enum logic [1:0] {
    HHID_SEL_IF_SHARED,
    HHID_SEL_EP_SHARED,
    HHID_SEL_IF_PERPORT,
    HHID_SEL_EP_PERPORT
  } hhid_sel_t;

  localparam logic [7:0]  HHID_IF_LEN        = 8'h09;
  localparam logic [7:0]  HHID_IF_TYPE       = 8'h04;
  localparam logic [7:0]  HHID_IF_NUM        = 8'h00;
  localparam logic [7:0]  HHID_ALT_SHARED    = 8'h00;
  localparam logic [7:0]  HHID_ALT_PERPORT   = 8'h01;
  localparam logic [7:0]  HHID_IF_EPS        = 8'h01;
  localparam logic [7:0]  HHID_IF_CLASS      = 8'h09;
  localparam logic [7:0]  HHID_IF_SUBCLASS   = 8'h00;
  localparam logic [7:0]  HHID_PROTO_ONE_IF  = 8'h00;
  localparam logic [7:0]  HHID_PROTO_TWO_IF  = 8'h01;
  localparam logic [7:0]  HHID_PROTO_PERPORT = 8'h02;
  localparam logic [7:0]  HHID_IF_STRING     = 8'h00;
  localparam logic [7:0]  HHID_IFCNT_ONE     = 8'h01;
  localparam logic [7:0]  HHID_IFCNT_TWO     = 8'h02;

  localparam logic [7:0]  HHID_EP_LEN        = 8'h07;
  localparam logic [7:0]  HHID_EP_TYPE       = 8'h05;
  localparam logic [7:0]  HHID_EP_ADDR       = 8'h81;
  localparam logic [7:0]  HHID_EP_ATTR       = 8'h03;
  localparam logic [15:0] HHID_EP_MAXPKT     = 16'h0001;
  localparam logic [7:0]  HHID_EP_INTERVAL   = 8'h0C;

  localparam logic [15:0] HHID_TOTAL_SHARED  = 16'h0019;
  localparam logic [15:0] HHID_TOTAL_PERPORT = 16'h0029;

  localparam logic [3:0]  HHID_IDX_RESET     = 4'h0;
  localparam logic [7:0]  HHID_DATA_RESET    = 8'h00;

endpackage

// File: hw/hhid_rom.sv
// Combinational descriptor byte lookup by variant and offset
`timescale 1ns/1ps
module hhid_rom
  import hhid_pkg::*;
(
  input  wire hhid_pkg::hhid_sel_t sel_in,       // Descriptor variant
  input  wire logic [3:0]          offset_in,    // Byte offset
  input  wire logic                two_if_in,    // Two interfaces reported
  output logic      [7:0]          byte_out      // Byte at offset
);
  import hhid_pkg::*;

  function automatic logic [7:0] if_byte(input logic [3:0] off, input logic [7:0] alt,
                                         input logic [7:0] proto);
    unique case (off)
      4'h0:    if_byte = HHID_IF_LEN;
      4'h1:    if_byte = HHID_IF_TYPE;
      4'h2:    if_byte = HHID_IF_NUM;
      4'h3:    if_byte = alt;
      4'h4:    if_byte = HHID_IF_EPS;
      4'h5:    if_byte = HHID_IF_CLASS;
      4'h6:    if_byte = HHID_IF_SUBCLASS;
      4'h7:    if_byte = proto;
      4'h8:    if_byte = HHID_IF_STRING;
      default: if_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] ep_byte(input logic [3:0] off);
    unique case (off)
      4'h0:    ep_byte = HHID_EP_LEN;
      4'h1:    ep_byte = HHID_EP_TYPE;
      4'h2:    ep_byte = HHID_EP_ADDR;
      4'h3:    ep_byte = HHID_EP_ATTR;
      4'h4:    ep_byte = HHID_EP_MAXPKT[7:0];
      4'h5:    ep_byte = HHID_EP_MAXPKT[15:8];
      4'h6:    ep_byte = HHID_EP_INTERVAL;
      default: ep_byte = 8'h00;
    endcase
  endfunction

  always_comb begin
    unique case (sel_in)
      HHID_SEL_IF_SHARED:  byte_out = if_byte(offset_in, HHID_ALT_SHARED,
                                              two_if_in ? HHID_PROTO_TWO_IF
                                                        : HHID_PROTO_ONE_IF);
      HHID_SEL_IF_PERPORT: byte_out = if_byte(offset_in, HHID_ALT_PERPORT,
                                              HHID_PROTO_PERPORT);
      HHID_SEL_EP_SHARED,
      HHID_SEL_EP_PERPORT: byte_out = ep_byte(offset_in);
    endcase
  end
endmodule

// File: hw/hhid_top.sv
// Streams high-speed interface and status-change endpoint descriptors
`timescale 1ns/1ps
module hhid_top
  import hhid_pkg::*;
(
  input  wire logic                mclk_in,                        // 40 MHz core clock
  input  wire logic                resetn_in,                      // Async reset, low
  input  wire logic                per_port_translator_option_in,  // Per-port support on
  input  wire logic [7:0]          interface_count_field_in,       // Interfaces reported
  input  wire logic                start_in,                       // Begin a descriptor
  input  wire hhid_pkg::hhid_sel_t sel_in,                         // Variant requested
  input  wire logic                next_in,                        // Consumer takes byte
  output logic                     busy_out,                       // Transfer in progress
  output logic                     valid_out,                      // Byte valid
  output logic      [7:0]          data_out,                       // Descriptor byte
  output logic                     last_out,                       // Final byte
  output logic                     refused_out,                    // Variant unavailable
  output logic      [15:0]         total_length_out                // Other-speed length
);
  import hhid_pkg::*;

  typedef enum logic [1:0] {HHID_IDLE, HHID_LOAD, HHID_SEND} hhid_state_t;

  typedef struct packed {
    hhid_state_t state;
    hhid_sel_t   sel;
    logic [3:0]  idx;
    logic [7:0]  data;
    logic        last;
    logic        refused;
    logic [15:0] total;
  } hhid_regs_t;

  hhid_regs_t cur_ff;
  hhid_regs_t nxt_cur;
  logic [7:0] rom_byte;
  logic [3:0] rom_off;

  function automatic logic [3:0] desc_len(input hhid_sel_t s);
    desc_len = (s == HHID_SEL_IF_SHARED || s == HHID_SEL_IF_PERPORT)
               ? HHID_IF_LEN[3:0] : HHID_EP_LEN[3:0];
  endfunction

  assign rom_off = (cur_ff.state == HHID_SEND) ? cur_ff.idx + 4'h1 : HHID_IDX_RESET;

  hhid_rom u_rom (
    .sel_in    (cur_ff.sel),
    .offset_in (rom_off),
    .two_if_in (interface_count_field_in == HHID_IFCNT_TWO),
    .byte_out  (rom_byte)
  );

  always_comb begin
    nxt_cur         = cur_ff;
    nxt_cur.refused = 1'b0;
    nxt_cur.total   = per_port_translator_option_in ? HHID_TOTAL_PERPORT
                                                    : HHID_TOTAL_SHARED;
    unique case (cur_ff.state)
      HHID_IDLE: begin
        if (start_in) begin
          if ((sel_in == HHID_SEL_IF_PERPORT || sel_in == HHID_SEL_EP_PERPORT)
              && !per_port_translator_option_in) begin
            nxt_cur.refused = 1'b1;
          end else begin
            nxt_cur.sel   = sel_in;
            nxt_cur.state = HHID_LOAD;
          end
        end
      end
      HHID_LOAD: begin
        nxt_cur.idx   = HHID_IDX_RESET;
        nxt_cur.data  = rom_byte;
        nxt_cur.last  = 1'b0;
        nxt_cur.state = HHID_SEND;
      end
      HHID_SEND: begin
        if (next_in) begin
          if (cur_ff.last) begin
            nxt_cur.state = HHID_IDLE;
            nxt_cur.last  = 1'b0;
          end else begin
            nxt_cur.idx  = cur_ff.idx + 4'h1;
            nxt_cur.data = rom_byte;
            nxt_cur.last = (cur_ff.idx + 4'h2) == desc_len(cur_ff.sel);
          end
        end
      end
      default: nxt_cur.state = HHID_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur_ff.state   <= HHID_IDLE;
      cur_ff.sel     <= HHID_SEL_IF_SHARED;
      cur_ff.idx     <= HHID_IDX_RESET;
      cur_ff.data    <= HHID_DATA_RESET;
      cur_ff.last    <= 1'b0;
      cur_ff.refused <= 1'b0;
      cur_ff.total   <= HHID_TOTAL_SHARED;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign busy_out         = cur_ff.state != HHID_IDLE;
  assign valid_out        = cur_ff.state == HHID_SEND;
  assign data_out         = cur_ff.data;
  assign last_out         = cur_ff.last;
  assign refused_out      = cur_ff.refused;
  assign total_length_out = cur_ff.total;
endmodule

// File: tb/hhid_host_model.sv
// Host-side consumer of descriptor bytes
`timescale 1ns/1ps
module hhid_host_model (
  input  wire logic mclk_in,   // Clock
  input  wire logic resetn_in, // Reset, low
  input  wire logic valid_in,  // Byte offered
  input  wire logic stall_in,  // Slow host
  output logic      next_out   // Byte taken
);
  logic ph_ff;
  // Slow mode takes only on alternate cycles, so bytes must stand
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ph_ff <= 1'b0;
      next_out <= 1'b0;
    end else begin
      ph_ff <= ~ph_ff;
      next_out <= valid_in && !(stall_in && ph_ff);
    end
  end
endmodule

// File: tb/hhid_top_chk.sv
// Port checker for the descriptor streamer
`timescale 1ns/1ps
module hhid_top_chk
  import hhid_pkg::*;
(
  input wire logic                mclk_in,                       // Clock
  input wire logic                resetn_in,                     // Reset
  input wire logic                per_port_translator_option_in, // Option
  input wire logic [7:0]          interface_count_field_in,      // Count
  input wire logic                start_in,                      // Begin
  input wire hhid_pkg::hhid_sel_t sel_in,                        // Variant
  input wire logic                next_in,                       // Taken
  input wire logic                busy_out,                      // Busy
  input wire logic                valid_out,                     // Valid
  input wire logic [7:0]          data_out,                      // Byte
  input wire logic                last_out,                      // Last
  input wire logic                refused_out,                   // Refused
  input wire logic [15:0]         total_length_out               // Length
);
  import hhid_pkg::*;
  logic [3:0] idx_ff;
  hhid_sel_t  sel_ff;
  logic       take;
  assign take = !busy_out && start_in;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx_ff <= 4'h0;
      sel_ff <= HHID_SEL_IF_SHARED;
    end else if (take) begin
      idx_ff <= 4'h0;
      sel_ff <= sel_in;
    end else if (valid_out && next_in) begin
      idx_ff <= idx_ff + 4'h1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  a_perport_refused: assert property (
    take && sel_in[1] && !per_port_translator_option_in |=> refused_out && !busy_out)
    else $error("per-port variant not refused");
  a_start_valid: assert property (
    take && !(sel_in[1] && !per_port_translator_option_in) |=> busy_out ##1 valid_out)
    else $error("start did not lead to a byte");
  a_first_length: assert property (
    $rose(valid_out) |-> data_out == (sel_ff[0] ? 8'h07 : 8'h09))
    else $error("wrong length byte");
  a_maxpkt_lsb: assert property (
    valid_out && sel_ff[0] && idx_ff == 4'h4 |-> data_out == 8'h01)
    else $error("packet size not low byte first");
  a_ep_interval: assert property (
    valid_out && sel_ff[0] && idx_ff == 4'h6 |-> data_out == 8'h0C && last_out)
    else $error("bad interval or last");
  a_if_proto: assert property (
    valid_out && !sel_ff[0] && idx_ff == 4'h7 |-> data_out == (sel_ff[1] ? 8'h02 :
    (interface_count_field_in == 8'h02 ? 8'h01 : 8'h00)))
    else $error("bad protocol byte");
  a_if_string: assert property (
    valid_out && !sel_ff[0] && idx_ff == 4'h8 |-> data_out == 8'h00 && last_out)
    else $error("bad string index or last");
  a_total_len: assert property (
    1'b1 |=> total_length_out == ($past(per_port_translator_option_in) ? 16'h0029 : 16'h0019))
    else $error("bad total length");
  a_byte_hold: assert property (
    valid_out && !next_in |=> valid_out && $stable(data_out))
    else $error("byte not held");
  c_refused: cover property (refused_out);
  c_stalled: cover property (valid_out && !next_in);
  c_pp_end: cover property (valid_out && last_out && sel_ff == HHID_SEL_EP_PERPORT);
endmodule

bind hhid_top hhid_top_chk i_hhid_top_chk (.*);

// File: tb/hhid_top_tb_top.sv
// Self-checking bench for the descriptor streamer
`timescale 1ns/1ps
module hhid_top_tb_top;
  import hhid_pkg::*;
  logic mclk_in = 1'b0, resetn_in = 1'b0, opt = 1'b0, start = 1'b0, stall = 1'b0;
  logic [7:0] cnt = 8'h01;
  hhid_sel_t sel = HHID_SEL_IF_SHARED;
  logic next, busy, valid, last, refused;
  logic [7:0] data;
  logic [15:0] total;
  logic [7:0] got[$];
  int lastpos, mismatches, tests_run, cyc;
  always #12.5 mclk_in = ~mclk_in;
  hhid_top i_hhid_top (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .per_port_translator_option_in(opt), .interface_count_field_in(cnt), .start_in(start),
    .sel_in(sel), .next_in(next), .busy_out(busy), .valid_out(valid), .data_out(data),
    .last_out(last), .refused_out(refused), .total_length_out(total));
  hhid_host_model i_hhid_host_model (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .valid_in(valid), .stall_in(stall), .next_out(next));
  always @(posedge mclk_in) begin
    if (valid === 1'b1 && next === 1'b1) begin
      got.push_back(data);
      if (last === 1'b1) lastpos = got.size();
    end
  end
  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic go(input hhid_sel_t s);
    @(posedge mclk_in);
    start <= 1'b1;
    sel <= s;
    @(posedge mclk_in);
    start <= 1'b0;
    @(negedge mclk_in);
  endtask
  // Expected bytes left-aligned in e, offset 0 first
  task automatic xfer(input hhid_sel_t s, input logic [71:0] e, input int n);
    int k;
    got = {};
    lastpos = 0;
    k = 0;
    go(s);
    check(refused === 1'b0, "legal start refused");
    while (busy !== 1'b0 && k < 100) begin
      @(negedge mclk_in);
      k++;
    end
    check(got.size() == n && lastpos == n, "byte count or last");
    for (int i = 0; i < n; i++) check(got[i] === e[71-8*i -: 8], "byte");
  endtask
  task automatic t_shared_if;
    cnt <= 8'h01;
    xfer(HHID_SEL_IF_SHARED, 72'h090400000109000000, 9);
    @(posedge mclk_in);
    cnt <= 8'h02;
    xfer(HHID_SEL_IF_SHARED, 72'h090400000109000100, 9);
  endtask
  task automatic t_shared_ep;
    @(posedge mclk_in);
    stall <= 1'b1;
    xfer(HHID_SEL_EP_SHARED, 72'h070581030100_0C0000, 7);
    @(posedge mclk_in);
    stall <= 1'b0;
  endtask
  task automatic t_perport_off;
    opt <= 1'b0;
    go(HHID_SEL_IF_PERPORT);
    check(refused === 1'b1 && busy === 1'b0, "not refused");
    go(HHID_SEL_EP_PERPORT);
    check(refused === 1'b1 && busy === 1'b0, "not refused");
    @(negedge mclk_in);
    check(refused === 1'b0, "refused held");
    check(total === 16'h0019, "length off");
  endtask
  task automatic t_perport_on;
    @(posedge mclk_in);
    opt <= 1'b1;
    repeat (2) @(negedge mclk_in);
    check(total === 16'h0029, "length on");
    xfer(HHID_SEL_IF_PERPORT, 72'h090400010109000200, 9);
    xfer(HHID_SEL_EP_PERPORT, 72'h070581030100_0C0000, 7);
  endtask
  task automatic wrap_up;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge mclk_in);
    resetn_in <= 1'b1;
    t_shared_if();
    t_shared_ep();
    t_perport_off();
    t_perport_on();
    wrap_up();
  end
endmodule
